// *** rtl/osccfg_pkg.sv ***
`default_nettype none
package osccfg_pkg;
  // word indices; byte address is four times the index
  localparam logic [29:0] IDX_RESET_CAUSE = 30'h0000_0740;
  localparam logic [29:0] IDX_OSC_CTRL = 30'h0000_0742;
  localparam logic [29:0] IDX_OSC_TUNE = 30'h0000_0748;
  localparam logic [29:0] IDX_OSC_TUNE_SEQ = 30'h0000_074A;
  localparam logic [29:0] IDX_PIN_IO = 30'h0000_0750;
  localparam logic [29:0] IDX_INIT_CFG = 30'h00F8_0006;
  localparam logic [29:0] IDX_PIN_CFG = 30'h00F8_0008;

  // initial oscillator configuration word
  localparam int SEL_LSB = 0;
  // oscillator pin configuration word
  localparam int PMODE_LSB = 0;
  localparam int CLKFUNC_BIT = 2;
  localparam int RANGE_BIT = 5;
  localparam int SWMON_LSB = 6;
  localparam logic [23:0] INIT_CFG_MASK = 24'h00_0003;
  localparam logic [23:0] PIN_CFG_MASK = 24'h00_00E7;

  // reset cause register
  localparam int RC_TRAP = 15;
  localparam int RC_ILLOP = 14;
  localparam int RC_PIN = 7;
  localparam int RC_SOFT = 6;
  localparam int RC_WDT_EN = 5;
  localparam int RC_WDT = 4;
  localparam int RC_SLEEP = 3;
  localparam int RC_IDLE = 2;
  localparam int RC_POR = 0;
  localparam logic [15:0] RC_WR_MASK = 16'hC0FD;
  localparam logic [15:0] RC_RST_VAL = 16'h0001;

  // oscillator control register
  localparam int OC_CUR_LSB = 12;
  localparam int OC_NEW_LSB = 8;
  localparam int OC_CLKLOCK = 7;
  localparam int OC_LOCK = 5;
  localparam int OC_PRCDEN = 4;
  localparam int OC_FAIL = 3;
  localparam int OC_TSEQEN = 2;
  localparam int OC_GO = 0;

  localparam logic [15:0] TUNE_RST_VAL = 16'h0000;
  localparam logic [1:0] PIN_IO_RST_VAL = 2'h0;
  localparam int PIO_OUT = 0;
  localparam int PIO_OE = 1;
  localparam int PIO_IN_SYNC = 8;
  localparam int PIO_PAD_SYNC = 9;

  // oscillator groups and oscillator pin modes
  localparam logic [2:0] OSC_FRC = 3'h0;
  localparam logic [1:0] PMODE_EXT = 2'h0;
  localparam logic [1:0] PMODE_RSVD = 2'h1;
  localparam logic [1:0] PMODE_XTAL = 2'h2;
  localparam logic [1:0] PMODE_OFF = 2'h3;
endpackage : osccfg_pkg
`default_nettype wire

// *** rtl/osccfg_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module osccfg_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage is read by the second stage only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule : osccfg_sync
`default_nettype wire

// *** rtl/osccfg_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module osccfg_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [23:0] init_osc_cfg_word,
  input wire logic [23:0] osc_pin_cfg_word,
  input wire logic trap_reset_evt,
  input wire logic illegal_op_reset_evt,
  input wire logic pin_reset_evt,
  input wire logic soft_reset_evt,
  input wire logic watchdog_timeout_evt,
  input wire logic sleep_wake_evt,
  input wire logic idle_wake_evt,
  input wire logic osc_in_pin,
  input wire logic osc_out_pin_i,
  input wire logic pll_lock_pin,
  input wire logic clk_fail_pin,
  output logic osc_out_pin_o,
  output logic osc_out_pin_oe,
  output logic osc_feedback_en,
  output logic pll_enable,
  output logic clk_switch_en,
  output logic fail_monitor_en,
  output logic [2:0] current_osc_sel
);
  import osccfg_pkg::*;

  logic osc_in_s, osc_out_s, lock_s, fail_s;

  osccfg_sync #(.W(4)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({osc_in_pin, osc_out_pin_i, pll_lock_pin, clk_fail_pin}),
    .q({osc_in_s, osc_out_s, lock_s, fail_s})
  );
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d, rd_data;
  logic [29:0] idx;
  logic wr_en, hit;
  logic cfg_done_q, cfg_done_d;
  logic [1:0] init_sel_q, init_sel_d;
  logic [1:0] sw_mon_q, sw_mon_d;
  logic range_q, range_d;
  logic clk_func_q, clk_func_d;
  logic [1:0] pmode_q, pmode_d;
  logic [15:0] reset_cause_control_q, reset_cause_control_d;
  logic [2:0] current_osc_sel_q, current_osc_sel_d, new_osc_sel_q, new_osc_sel_d;
  logic clklock_q, clklock_d, prcden_q, prcden_d;
  logic cf_q, cf_d, tseqen_q, tseqen_d, osc_switch_go_q, osc_switch_go_d;
  logic [15:0] tune_q, tune_d, tune_seq_q, tune_seq_d;
  logic [1:0] pin_io_q, pin_io_d;
  logic sw_en_q, sw_en_d, mon_en_q, mon_en_d, pll_q, pll_d;
  logic first_q;
  logic out_o_q, out_o_d, out_oe_q, out_oe_d, fb_q, fb_d, clk_out_en;
  assign idx = paddr[31:2];
  assign wr_en = psel & penable & pready_q & pwrite;
  always_comb begin
    hit = 1'b1;
    rd_data = 32'h0000_0000;
    case (idx)
      IDX_RESET_CAUSE: rd_data[15:0] = reset_cause_control_q;
      IDX_OSC_CTRL: begin
        rd_data[OC_CUR_LSB +: 3] = current_osc_sel_q;
        rd_data[OC_NEW_LSB +: 3] = new_osc_sel_q;
        rd_data[OC_CLKLOCK] = clklock_q;
        rd_data[OC_LOCK] = lock_s;
        rd_data[OC_PRCDEN] = prcden_q;
        rd_data[OC_FAIL] = cf_q;
        rd_data[OC_TSEQEN] = tseqen_q;
        rd_data[OC_GO] = osc_switch_go_q;
      end
      IDX_OSC_TUNE: rd_data[15:0] = tune_q;
      IDX_OSC_TUNE_SEQ: rd_data[15:0] = tune_seq_q;
      IDX_PIN_IO: begin
        rd_data[1:0] = pin_io_q;
        rd_data[PIO_IN_SYNC] = osc_in_s;
        rd_data[PIO_PAD_SYNC] = osc_out_s;
      end
      IDX_INIT_CFG: rd_data[SEL_LSB +: 2] = init_sel_q;
      IDX_PIN_CFG: begin
        rd_data[SWMON_LSB +: 2] = sw_mon_q;
        rd_data[RANGE_BIT] = range_q;
        rd_data[CLKFUNC_BIT] = clk_func_q;
        rd_data[PMODE_LSB +: 2] = pmode_q;
      end
      default: hit = 1'b0;
    endcase
  end
  // answer one cycle after setup, so the access phase lasts one cycle
  always_comb begin
    pready_d = psel & ~penable;
    pslverr_d = psel & ~penable & ~hit;
    prdata_d = (psel & ~penable & ~pwrite) ? rd_data : 32'h0000_0000;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end
  always_comb begin
    cfg_done_d = 1'b1;
    init_sel_d = init_sel_q;
    sw_mon_d = sw_mon_q;
    range_d = range_q;
    clk_func_d = clk_func_q;
    pmode_d = pmode_q;
    reset_cause_control_d = reset_cause_control_q;
    current_osc_sel_d = current_osc_sel_q;
    new_osc_sel_d = new_osc_sel_q;
    clklock_d = clklock_q;
    prcden_d = prcden_q;
    cf_d = cf_q;
    tseqen_d = tseqen_q;
    osc_switch_go_d = osc_switch_go_q;
    tune_d = tune_q;
    tune_seq_d = tune_seq_q;
    pin_io_d = pin_io_q;
    if (!cfg_done_q) begin
      init_sel_d = init_osc_cfg_word[SEL_LSB +: 2];
      sw_mon_d = osc_pin_cfg_word[SWMON_LSB +: 2];
      range_d = osc_pin_cfg_word[RANGE_BIT];
      clk_func_d = osc_pin_cfg_word[CLKFUNC_BIT];
      pmode_d = osc_pin_cfg_word[PMODE_LSB +: 2];
      current_osc_sel_d = {1'b0, init_osc_cfg_word[SEL_LSB +: 2]};
      new_osc_sel_d = {1'b0, init_osc_cfg_word[SEL_LSB +: 2]};
    end else begin
      if (wr_en && idx == IDX_RESET_CAUSE) begin
        reset_cause_control_d = pwdata[15:0] & RC_WR_MASK;
      end
      if (wr_en && idx == IDX_OSC_CTRL) begin
        new_osc_sel_d = pwdata[OC_NEW_LSB +: 3];
        clklock_d = pwdata[OC_CLKLOCK];
        prcden_d = pwdata[OC_PRCDEN];
        cf_d = cf_q & pwdata[OC_FAIL];
        tseqen_d = pwdata[OC_TSEQEN];
        osc_switch_go_d = pwdata[OC_GO];
      end
      if (wr_en && idx == IDX_OSC_TUNE) begin
        tune_d = pwdata[15:0];
      end
      if (wr_en && idx == IDX_OSC_TUNE_SEQ) begin
        tune_seq_d = pwdata[15:0];
      end
      if (wr_en && idx == IDX_PIN_IO) begin
        pin_io_d = pwdata[1:0];
      end
      // switch request honoured only when switching is on
      if (osc_switch_go_q) begin
        osc_switch_go_d = 1'b0;
        if (!sw_mon_q[1]) begin
          current_osc_sel_d = new_osc_sel_q;
        end
      end
      // monitor falls back to rc; fail flag set wins over clear
      if (sw_mon_q == 2'b00 && fail_s) begin
        cf_d = 1'b1;
        current_osc_sel_d = OSC_FRC;
      end
    end
    // cause flags, set wins over software clear
    if (trap_reset_evt) reset_cause_control_d[RC_TRAP] = 1'b1;
    if (illegal_op_reset_evt) reset_cause_control_d[RC_ILLOP] = 1'b1;
    if (pin_reset_evt) reset_cause_control_d[RC_PIN] = 1'b1;
    if (soft_reset_evt) reset_cause_control_d[RC_SOFT] = 1'b1;
    if (watchdog_timeout_evt) reset_cause_control_d[RC_WDT] = 1'b1;
    if (sleep_wake_evt) reset_cause_control_d[RC_SLEEP] = 1'b1;
    if (idle_wake_evt) reset_cause_control_d[RC_IDLE] = 1'b1;
    sw_en_d = ~sw_mon_d[1];
    mon_en_d = (sw_mon_d == 2'b00);
    pll_d = current_osc_sel_d[0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_done_q <= 1'b0;
      init_sel_q <= 2'h0;
      sw_mon_q <= 2'h3;
      range_q <= 1'b0;
      clk_func_q <= 1'b0;
      pmode_q <= PMODE_OFF;
      reset_cause_control_q <= RC_RST_VAL;
      current_osc_sel_q <= OSC_FRC;
      new_osc_sel_q <= OSC_FRC;
      clklock_q <= 1'b0;
      prcden_q <= 1'b0;
      cf_q <= 1'b0;
      tseqen_q <= 1'b0;
      osc_switch_go_q <= 1'b0;
      tune_q <= TUNE_RST_VAL;
      tune_seq_q <= TUNE_RST_VAL;
      pin_io_q <= PIN_IO_RST_VAL;
      sw_en_q <= 1'b0;
      mon_en_q <= 1'b0;
      pll_q <= 1'b0;
      first_q <= 1'b1;
    end else begin
      cfg_done_q <= cfg_done_d;
      init_sel_q <= init_sel_d;
      sw_mon_q <= sw_mon_d;
      range_q <= range_d;
      clk_func_q <= clk_func_d;
      pmode_q <= pmode_d;
      reset_cause_control_q <= reset_cause_control_d;
      current_osc_sel_q <= current_osc_sel_d;
      new_osc_sel_q <= new_osc_sel_d;
      clklock_q <= clklock_d;
      prcden_q <= prcden_d;
      cf_q <= cf_d;
      tseqen_q <= tseqen_d;
      osc_switch_go_q <= osc_switch_go_d;
      tune_q <= tune_d;
      tune_seq_q <= tune_seq_d;
      pin_io_q <= pin_io_d;
      sw_en_q <= sw_en_d;
      mon_en_q <= mon_en_d;
      pll_q <= pll_d;
      first_q <= 1'b0;
    end
  end
  // clock out only once configuration is known
  assign clk_out_en = cfg_done_q & clk_func_q;
  always_comb begin
    // pclk stands for Fosc, a toggle each cycle gives Fosc/2
    out_o_d = clk_out_en ? ~out_o_q : pin_io_q[PIO_OUT];
    // otherwise the pad is plain general I/O
    out_oe_d = clk_out_en | pin_io_q[PIO_OE];
    // feedback only for a crystal; off, reserved and external keep it off
    fb_d = cfg_done_q & (pmode_q == PMODE_XTAL);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_o_q <= 1'b0;
      out_oe_q <= 1'b0;
      fb_q <= 1'b0;
    end else begin
      out_o_q <= out_o_d;
      out_oe_q <= out_oe_d;
      fb_q <= fb_d;
    end
  end
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign osc_out_pin_o = out_o_q;
  assign osc_out_pin_oe = out_oe_q;
  assign osc_feedback_en = fb_q;
  assign pll_enable = pll_q;
  assign clk_switch_en = sw_en_q;
  assign fail_monitor_en = mon_en_q;
  assign current_osc_sel = current_osc_sel_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_cfg_load;
    !cfg_done_q ##1 cfg_done_q;
  endsequence
  sequence s_clk_on;
    cfg_done_q && clk_func_q;
  endsequence
  property p_init_group;
    s_cfg_load |-> current_osc_sel_q == {1'b0, init_sel_q} && pll_enable == init_sel_q[0];
  endproperty
  a_init_group: assert property (p_init_group) else $error("initial group wrong");
  property p_switch_mon;
    cfg_done_q |-> clk_switch_en == !sw_mon_q[1] && fail_monitor_en == (sw_mon_q == 2'b00);
  endproperty
  a_switch_mon: assert property (p_switch_mon) else $error("switch/monitor enables wrong");
  property p_switch_block;
    cfg_done_q && osc_switch_go_q && sw_mon_q[1] && !(wr_en && idx == IDX_OSC_CTRL)
      |=> !osc_switch_go_q && $stable(current_osc_sel_q);
  endproperty
  a_switch_block: assert property (p_switch_block) else $error("switch not blocked");
  property p_clk_out;
    s_clk_on ##1 s_clk_on |-> osc_out_pin_oe && osc_out_pin_o != $past(osc_out_pin_o);
  endproperty
  a_clk_out: assert property (p_clk_out) else $error("clock out not toggling");
  property p_feedback;
    cfg_done_q ##1 1'b1 |-> osc_feedback_en == ($past(pmode_q) == PMODE_XTAL);
  endproperty
  a_feedback: assert property (p_feedback) else $error("feedback enable wrong");
  property p_half_rate;
    (cfg_done_q && clk_func_q && pmode_q == PMODE_EXT)[*3] |->
      osc_out_pin_o == $past(osc_out_pin_o, 2);
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("output not Fosc/2");
  property p_ext_io;
    cfg_done_q && !clk_func_q && pmode_q == PMODE_EXT |=>
      osc_out_pin_oe == $past(pin_io_q[PIO_OE]) && !osc_feedback_en;
  endproperty
  a_ext_io: assert property (p_ext_io) else $error("pad not general I/O");
  property p_ctrl_load;
    s_cfg_load |-> new_osc_sel_q == current_osc_sel_q && !osc_switch_go_q && !cf_q;
  endproperty
  a_ctrl_load: assert property (p_ctrl_load) else $error("control not loaded");
  property p_por_flag;
    first_q |-> reset_cause_control_q == RC_RST_VAL;
  endproperty
  a_por_flag: assert property (p_por_flag) else $error("power-on cause missing");
  property p_trap_set;
    trap_reset_evt |=> reset_cause_control_q[RC_TRAP];
  endproperty
  a_trap_set: assert property (p_trap_set) else $error("trap flag lost");
  property p_cfg_hold;
    cfg_done_q |=> $stable(init_sel_q) && $stable(sw_mon_q) && $stable(pmode_q)
      && $stable(clk_func_q);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("configuration changed");
endmodule : osccfg_top
`default_nettype wire

// *** verif/osccfg_osc_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module osccfg_osc_model (
  input wire logic run_clk,
  input wire logic lock_lvl,
  input wire logic fail_lvl,
  input wire logic pad_lvl,
  input wire logic pad_o,
  input wire logic pad_oe,
  output logic osc_in,
  output logic pad_i,
  output logic lock,
  output logic fail
);
  // driven clock into the input
  // period unrelated to pclk so the synchronisers see real skew
  initial osc_in = 1'b0;
  always begin
    #7.3;
    osc_in = run_clk ? ~osc_in : 1'b0;
  end
  // pad wire resolution
  // board level only where the device releases the pad
  assign pad_i = pad_oe ? pad_o : pad_lvl;
  assign lock = lock_lvl;
  assign fail = fail_lvl;
endmodule : osccfg_osc_model
`default_nettype wire

// *** verif/oscillator_source_config_test.sv ***
`timescale 1ns/100ps
`default_nettype none
module oscillator_source_config_test;
  import osccfg_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [23:0] init_w = 24'h0;
  logic [23:0] pin_w = 24'h0;
  logic [6:0] evt = 7'h0;
  logic lock_lvl = 1'b0;
  logic fail_lvl = 1'b0;
  logic run_clk = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, osc_in, pad_i, lock, fail, pad_o, pad_oe;
  logic fb_en, pll_en, sw_en, mon_en;
  logic [2:0] cur_sel;
  int n_errors = 0;
  int checks = 0;
  logic [31:0] xs_q = 32'd34;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic err_q[$];
  logic [15:0] evb [7] = '{16'h8000, 16'h4000, 16'h0080, 16'h0040, 16'h0010, 16'h0008, 16'h0004};

  always #5 pclk = ~pclk;

  osccfg_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .init_osc_cfg_word(init_w), .osc_pin_cfg_word(pin_w),
    .trap_reset_evt(evt[0]), .illegal_op_reset_evt(evt[1]), .pin_reset_evt(evt[2]),
    .soft_reset_evt(evt[3]), .watchdog_timeout_evt(evt[4]), .sleep_wake_evt(evt[5]),
    .idle_wake_evt(evt[6]), .osc_in_pin(osc_in), .osc_out_pin_i(pad_i),
    .pll_lock_pin(lock), .clk_fail_pin(fail), .osc_out_pin_o(pad_o),
    .osc_out_pin_oe(pad_oe), .osc_feedback_en(fb_en), .pll_enable(pll_en),
    .clk_switch_en(sw_en), .fail_monitor_en(mon_en), .current_osc_sel(cur_sel));

  osccfg_osc_model partner (.run_clk(run_clk), .lock_lvl(lock_lvl), .fail_lvl(fail_lvl),
    .pad_lvl(1'b1), .pad_o(pad_o), .pad_oe(pad_oe), .osc_in(osc_in), .pad_i(pad_i),
    .lock(lock), .fail(fail));

  function automatic logic [31:0] xs_next(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs_next

  function automatic logic [31:0] ba(input logic [29:0] i);
    return {i, 2'b00};
  endfunction : ba

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // the request is held until pready is sampled high, then released
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     input logic [31:0] exp, input logic [31:0] msk, input logic err);
    int n;
    exp_q.push_back(exp);
    msk_q.push_back(msk);
    err_q.push_back(err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      report_and_stop();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask : wr

  // answers carry register values after reset, access kinds and held words
  always @(negedge pclk) begin
    if (pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("unrequested answer", 32'h1, 32'h0);
      end else begin
        chk("read data", prdata & msk_q.pop_front(), exp_q.pop_front());
        chk("slave error", {31'h0, pslverr}, {31'h0, err_q.pop_front()});
      end
    end
  end

  initial begin
    repeat (60000) @(posedge pclk);
    n_errors++;
    report_and_stop();
  end

  initial begin
    logic [1:0] k;
    logic [15:0] acc;
    logic prev;
    int n;
    for (int kk = 0; kk < 4; kk++) begin
      k = kk[1:0];
      xs_q = xs_next(xs_q);
      @(posedge pclk);
      presetn <= 1'b0;
      init_w <= {xs_q[23:2], k};
      // k=1 runs external clock with general I/O, so both external-clock pad uses are seen
      pin_w <= {xs_q[23:8], k, xs_q[5:3], ~k[0], (k == 2'h1) ? PMODE_EXT : k};
      lock_lvl <= 1'b1;
      run_clk <= (k == 2'h0);
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      init_w <= ~init_w;
      pin_w <= ~pin_w;
      repeat (3) @(posedge pclk);
      chk("current sel", {29'h0, cur_sel}, {30'h0, k});
      chk("pll enable", {31'h0, pll_en}, {31'h0, k[0]});
      chk("switch en", {31'h0, sw_en}, {31'h0, ~k[1]});
      chk("monitor en", {31'h0, mon_en}, {31'h0, k == 2'h0});
      chk("feedback", {31'h0, fb_en}, {31'h0, k == 2'h2});
      apb(1'b0, ba(IDX_OSC_CTRL), 0, 32'(k) << 12 | 32'(k) << 8 | 32'h20, 32'h7720, 0);
      apb(1'b0, ba(IDX_RESET_CAUSE), 0, 32'h1, 32'hFFFFFFFF, 0);
      wr(ba(IDX_INIT_CFG), 32'hFFFFFFFF);
      apb(1'b0, ba(IDX_INIT_CFG), 0, 32'(k), 32'hFFFFFFFF, 0);
      apb(1'b0, ba(IDX_PIN_CFG), 0, 32'(~pin_w & PIN_CFG_MASK), 32'hFFFFFFFF, 0);
      apb(1'b0, ba(30'h741), 0, 32'h0, 32'hFFFFFFFF, 1'b1);
      apb(1'b0, ba(IDX_OSC_TUNE), 0, 32'h0, 32'hFFFFFFFF, 0);
      wr(ba(IDX_OSC_TUNE), xs_q);
      apb(1'b0, ba(IDX_OSC_TUNE), 0, xs_q & 32'hFFFF, 32'hFFFFFFFF, 0);
      if (!k[0]) begin
        @(negedge pclk);
        prev = pad_o;
        @(negedge pclk);
        chk("clock out", {30'h0, pad_oe, pad_o}, {30'h0, 1'b1, ~prev});
      end else begin
        wr(ba(IDX_PIN_IO), 32'h3);
        repeat (3) @(posedge pclk);
        chk("pad io", {30'h0, pad_oe, pad_o}, 32'h3);
        wr(ba(IDX_PIN_IO), 32'h2);
        repeat (4) @(posedge pclk);
        apb(1'b0, ba(IDX_PIN_IO), 0, 32'h2, 32'h203, 0);
        // released pad shows the board pull-up
        wr(ba(IDX_PIN_IO), 32'h0);
        repeat (4) @(posedge pclk);
        apb(1'b0, ba(IDX_PIN_IO), 0, 32'h200, 32'h203, 0);
      end
      wr(ba(IDX_OSC_CTRL), 32'h0301);
      repeat (3) @(posedge pclk);
      chk("switched sel", {29'h0, cur_sel}, k[1] ? {30'h0, k} : 32'h3);
      if (k == 2'h0) begin
        fail_lvl <= 1'b1;
        n = 0;
        while (cur_sel !== 3'h0 && n < 10) begin
          @(posedge pclk);
          n++;
        end
        chk("fail sel", {29'h0, cur_sel}, 32'h0);
        apb(1'b0, ba(IDX_OSC_CTRL), 0, 32'h8, 32'h8, 0);
        fail_lvl <= 1'b0;
      end
      if (k == 2'h3) begin
        wr(ba(IDX_RESET_CAUSE), 32'hFFFF);
        apb(1'b0, ba(IDX_RESET_CAUSE), 0, 32'hC0FD, 32'hFFFFFFFF, 0);
        wr(ba(IDX_RESET_CAUSE), 32'h0);
        acc = 16'h0;
        for (int i = 0; i < 7; i++) begin
          @(posedge pclk);
          evt <= 7'(1 << i);
          @(posedge pclk);
          evt <= 7'h0;
          acc = acc | evb[i];
          apb(1'b0, ba(IDX_RESET_CAUSE), 0, 32'(acc), 32'hFFFFFFFF, 0);
        end
      end
    end
    repeat (5) @(posedge pclk);
    report_and_stop();
  end
endmodule : oscillator_source_config_test
`default_nettype wire
